// *** rtl/dacf_osc.sv ***
`timescale 1ns/1ns
`default_nettype none
module dacf_osc (
  // Clock and control
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  input wire logic restart,
  // Tick out
  output logic tick
);
  import dacf_pkg::*;
  logic [7:0] cnt_q;
  // Stopped and parked at zero whenever not running
  always_ff @(posedge sys_clk)
  begin
    if (rst || !run || restart)
      cnt_q <= 8'h00; // R7
    else if (ce)
      cnt_q <= (cnt_q == 8'(OSC_CYC - 1)) ? 8'h00 : cnt_q + 8'h01; // R5
  end
  assign tick = run && ce && (cnt_q == 8'(OSC_CYC - 1));
endmodule : dacf_osc
`default_nettype wire

// *** rtl/dacf_pkg.sv ***
// Notes on behaviour
// (R1) Far side keeps continuous sample clock at or below 8 MSPS divided by channels.
// (R2) Far side spaces start pulses: 4 MSPS one channel, 2.67 MSPS two channels.
// (R3) Mode bit 1 of control word A set to 1 selects single-shot conversion.
// (R4) Single-shot: start falling edge holds all selected inputs together, starts conversion.
// (R5) Single-shot conversion steps are timed by the internal oscillator only.
// (R6) Trigger equal to channel count: words ready after pipeline plus n conversion times.
// (R7) Continuous mode stops the internal oscillator; sample clock times everything.
// (R8) Mode bit 1 cleared: one new word into the buffer per sample clock rise.
// (R9) Single-shot converts one or two selected channels per start event.
// (R10) Two channels are written in fixed order, channel 0 first.
// (R11) Binary single-ended coding: 3FF at top, 200 at midpoint, 000 at bottom.
// (R12) Twos-complement single-ended coding: 1FF at top, 000 midpoint, 200 bottom.
// (R13) Differential input uses the same two codings for the input difference.
// (R14) Every result goes automatically into a 16-word circular buffer.
// (R15) Buffer keeps read pointer, last-written write pointer and trigger pointer.
// (R16) Words ready asserts once new entries reach the programmed trigger depth.
// (R17) Far side reads trigger-depth words per event, channel 0 word first.
// (R18) Buffer overrun goes high on overflow, held until reset or buffer reset.
// (R19) Continuous: first words ready comes 7 plus trigger-depth clock rises after reset.
// (R20) Words ready is a low-going pulse.
// (R21) One channel offers trigger depths 1, 4, 8 and 14.
// (R22) Read and write pointers step by one and wrap modulo 16.
package dacf_pkg;
  localparam int DW = 10;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 5;
  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [DW-1:0] CTRL_A_RESET = 10'h000;
  localparam logic [DW-1:0] CTRL_B_RESET = 10'h000;
  localparam int A_MODE_BIT = 1;
  localparam int A_CHSEL0_BIT = 3;
  localparam int A_CHSEL1_BIT = 4;
  localparam int A_DIFF_BIT = 5;
  localparam int B_FRST_BIT = 1;
  localparam int B_TRIG_LO = 2;
  localparam int B_TWOS_BIT = 7;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_NS = 8;
  localparam int OSC_PERIOD_NS = 125;
  localparam int OSC_CYC = (OSC_PERIOD_NS / SYS_CLK_NS < 1) ? 1 : OSC_PERIOD_NS / SYS_CLK_NS;
  localparam int SS_PIPE_TICKS = 7;
  localparam int SS_CONV_TICKS = 2;
  localparam logic [3:0] CONT_PIPE_EDGES = 4'h7;
  typedef enum logic [1:0] {SS_IDLE = 2'b00, SS_PIPE = 2'b01, SS_CONV = 2'b11} dacf_ss_t;
  // Trigger depth table, one channel and two channels
  function automatic logic [CNT_W-1:0] dacf_trig(input logic [1:0] code, input logic two);
    logic [CNT_W-1:0] lvl;
    lvl = 5'h01;
    case (code)
      2'h0: lvl = two ? 5'h02 : 5'h01;
      2'h1: lvl = 5'h04;
      2'h2: lvl = 5'h08;
      default: lvl = two ? 5'h0C : 5'h0E;
    endcase
    return lvl;
  endfunction : dacf_trig
  // Raw converter word is offset binary; twos form flips the MSB
  function automatic logic [DW-1:0] dacf_code(input logic [DW-1:0] raw, input logic twos);
    return twos ? {~raw[DW-1], raw[DW-2:0]} : raw;
  endfunction : dacf_code
endpackage : dacf_pkg

// *** rtl/dacf_ring.sv ***
`timescale 1ns/1ns
`default_nettype none
module dacf_ring #(
  parameter int DEPTH = dacf_pkg::FIFO_DEPTH
) (
  // Clock and control
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clear,
  // Write side
  dacf_word_if.snk wr,
  // Read side
  input wire logic pop,
  input wire logic [dacf_pkg::CNT_W-1:0] trig_level,
  output logic [dacf_pkg::DW-1:0] rd_data,
  output logic [dacf_pkg::CNT_W-1:0] count,
  output logic words_ready_n,
  output logic overrun
);
  import dacf_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [DW-1:0] mem_q [DEPTH];
  logic [AW-1:0] rd_ptr_q, wr_ptr_q, wr_next;
  logic [CNT_W-1:0] count_q, trig_cnt_q;
  logic do_pop, full, accept;
  assign do_pop = pop && (count_q != '0);
  assign full = (count_q == CNT_W'(DEPTH));
  assign accept = wr.valid && (!full || do_pop);
  assign wr_next = wr_ptr_q + 1'b1; // R22
  assign rd_data = mem_q[rd_ptr_q];
  assign count = count_q;
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_ent
      always_ff @(posedge sys_clk)
      begin
        if (ce && accept && wr_next == AW'(g))
          mem_q[g] <= wr.data; // R14
      end
    end
  endgenerate
  // Write pointer marks last written entry, read pointer next to read
  always_ff @(posedge sys_clk)
  begin
    if (rst || (ce && clear))
    begin
      wr_ptr_q <= AW'(DEPTH - 1);
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else if (ce)
    begin
      if (accept)
        wr_ptr_q <= wr_next; // R15
      if (do_pop)
        rd_ptr_q <= rd_ptr_q + 1'b1; // R22
      count_q <= count_q + CNT_W'(accept) - CNT_W'(do_pop);
    end
  end
  // Trigger pointer counts new entries since the last event
  always_ff @(posedge sys_clk)
  begin
    if (rst || (ce && clear))
    begin
      trig_cnt_q <= '0;
      words_ready_n <= 1'b1;
    end
    else if (ce)
    begin
      words_ready_n <= 1'b1;
      if (accept)
      begin
        if (trig_cnt_q + 5'h01 >= trig_level)
        begin
          trig_cnt_q <= '0;
          words_ready_n <= 1'b0; // R16 R20
        end
        else
          trig_cnt_q <= trig_cnt_q + 5'h01;
      end
    end
  end
  // Word dropped on overflow; flag set wins over a same-cycle clear
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      overrun <= 1'b0;
    else if (ce)
      overrun <= (wr.valid && !accept) || (overrun && !clear); // R18
  end
  property p_overrun_sticky;
    @(posedge sys_clk) disable iff (rst) overrun && !clear |=> overrun;
  endproperty
  a_overrun_sticky: assert property (p_overrun_sticky) else $error("overrun dropped"); // R18
  property p_ready_pulse;
    @(posedge sys_clk) disable iff (rst) !words_ready_n |=> words_ready_n;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready not a pulse"); // R20
  property p_count_bound;
    @(posedge sys_clk) disable iff (rst) count_q <= CNT_W'(DEPTH);
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("count over depth"); // R14
  property p_ptr_gap;
    @(posedge sys_clk) disable iff (rst) AW'(wr_ptr_q + 1'b1 - rd_ptr_q) == AW'(count_q);
  endproperty
  a_ptr_gap: assert property (p_ptr_gap) else $error("pointers and count disagree"); // R22
  c_overflow: cover property (@(posedge sys_clk) disable iff (rst) $rose(overrun));
endmodule : dacf_ring
`default_nettype wire

// *** rtl/dacf_top.sv ***
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module dacf_top (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Converter side
  input wire logic start_pulse_n,
  input wire logic sample_clock_in,
  input wire logic [dacf_pkg::DW-1:0] raw_ch0,
  input wire logic [dacf_pkg::DW-1:0] raw_ch1,
  // Status pins
  output logic words_ready_n,
  output logic buffer_overrun
);
  import dacf_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [DW-1:0] control_word_a_q, control_word_b_q;
  logic fifo_clr_q;
  logic acc_q, wr_q;
  logic [7:0] addr_q;
  logic take, rd_take, pop;
  logic single_mode, two_ch, twos_comp;
  logic [CNT_W-1:0] trigger_depth, fifo_count;
  logic [DW-1:0] fifo_rd;
  logic [31:0] rd_mux;

  assign single_mode = control_word_a_q[A_MODE_BIT]; // R3
  assign two_ch = control_word_a_q[A_CHSEL0_BIT] && control_word_a_q[A_CHSEL1_BIT]
                  && !control_word_a_q[A_DIFF_BIT]; // R9
  assign twos_comp = control_word_b_q[B_TWOS_BIT];
  assign trigger_depth = dacf_trig(control_word_b_q[B_TRIG_LO +: 2], two_ch); // R21

  assign take = hsel && hready && htrans[1];
  assign rd_take = take && !hwrite;
  assign pop = rd_take && (haddr[7:0] == ADDR_DATA);

  // Address phase captured for the following data phase
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      acc_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else if (ce)
    begin
      acc_q <= take;
      if (take)
      begin
        wr_q <= hwrite;
        addr_q <= haddr[7:0];
      end
    end
  end

  // Buffer reset bit is a self-clearing strobe, never stored
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      control_word_a_q <= CTRL_A_RESET;
      control_word_b_q <= CTRL_B_RESET;
      fifo_clr_q <= 1'b0;
    end
    else if (ce)
    begin
      fifo_clr_q <= 1'b0;
      if (acc_q && wr_q)
      begin
        case (addr_q)
          ADDR_CTRL_A: control_word_a_q <= hwdata[DW-1:0];
          ADDR_CTRL_B:
          begin
            control_word_b_q <= hwdata[DW-1:0] & ~(10'h001 << B_FRST_BIT);
            fifo_clr_q <= hwdata[B_FRST_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  // Read data chosen at the address phase; unmapped reads give zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      ADDR_CTRL_A: rd_mux = {22'h00_0000, control_word_a_q};
      ADDR_CTRL_B: rd_mux = {22'h00_0000, control_word_b_q};
      ADDR_DATA: rd_mux = (fifo_count != '0) ? {22'h00_0000, fifo_rd} : 32'h0000_0000;
      ADDR_STATUS: rd_mux = {23'h00_0000, fifo_count, 2'h0, single_mode, buffer_overrun};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (ce)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_take)
        hrdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  dacf_word_if word_bus ();
  dacf_ss_t ss_q;
  logic start_prev_q, samp_prev_q;
  logic start_fall, samp_rise, osc_tick;
  logic [DW-1:0] hold0_q, hold1_q;
  logic chan_q;
  logic [3:0] tick_cnt_q;
  logic [3:0] fill_q;

  assign start_fall = start_prev_q && !start_pulse_n;
  assign samp_rise = sample_clock_in && !samp_prev_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      start_prev_q <= 1'b1;
      samp_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      start_prev_q <= start_pulse_n;
      samp_prev_q <= sample_clock_in;
    end
  end

  // Restarted on each start edge taken in idle so step timing is fixed from that edge
  dacf_osc u_osc (
    .sys_clk (sys_clk),
    .rst (rst),
    .ce (ce),
    .run (single_mode), // R7
    .restart (ss_q == SS_IDLE && start_fall),
    .tick (osc_tick)
  );

  // Mode change mid-sequence simply drops back to idle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ss_q <= SS_IDLE;
      hold0_q <= '0;
      hold1_q <= '0;
      chan_q <= 1'b0;
      tick_cnt_q <= 4'h0;
      fill_q <= 4'h0;
      word_bus.valid <= 1'b0;
      word_bus.data <= '0;
    end
    else if (ce)
    begin
      word_bus.valid <= 1'b0;
      if (fifo_clr_q)
      begin
        ss_q <= SS_IDLE;
        chan_q <= 1'b0;
        fill_q <= 4'h0;
      end
      else if (single_mode)
      begin
        fill_q <= 4'h0;
        case (ss_q)
          SS_IDLE:
          begin
            if (start_fall)
            begin
              hold0_q <= raw_ch0; // R4
              hold1_q <= raw_ch1; // R4
              chan_q <= 1'b0;
              tick_cnt_q <= 4'h0;
              ss_q <= SS_PIPE;
            end
          end
          SS_PIPE:
          begin
            if (osc_tick)
            begin
              if (tick_cnt_q == 4'(SS_PIPE_TICKS - 1))
              begin
                tick_cnt_q <= 4'h0;
                ss_q <= SS_CONV; // R6
              end
              else
                tick_cnt_q <= tick_cnt_q + 4'h1;
            end
          end
          SS_CONV:
          begin
            if (osc_tick)
            begin
              if (tick_cnt_q == 4'(SS_CONV_TICKS - 1))
              begin
                tick_cnt_q <= 4'h0;
                word_bus.valid <= 1'b1; // R6
                word_bus.data <= dacf_code(chan_q ? hold1_q : hold0_q, twos_comp); // R11 R12 R13
                if (two_ch && !chan_q)
                  chan_q <= 1'b1; // R10
                else
                begin
                  chan_q <= 1'b0;
                  ss_q <= SS_IDLE;
                end
              end
              else
                tick_cnt_q <= tick_cnt_q + 4'h1;
            end
          end
          default: ss_q <= SS_IDLE;
        endcase
      end
      else
      begin
        ss_q <= SS_IDLE;
        if (samp_rise)
        begin
          if (fill_q != CONT_PIPE_EDGES)
            fill_q <= fill_q + 4'h1; // R19
          else
          begin
            word_bus.valid <= 1'b1; // R8
            word_bus.data <= dacf_code(chan_q ? raw_ch1 : raw_ch0, twos_comp); // R11 R12 R13
            chan_q <= two_ch ? !chan_q : 1'b0; // R10
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Buffer
  // ----------------------------------------------------------------
  dacf_ring #(
    .DEPTH (FIFO_DEPTH)
  ) u_ring (
    .sys_clk (sys_clk),
    .rst (rst),
    .ce (ce),
    .clear (fifo_clr_q),
    .wr (word_bus.snk),
    .pop (pop && ce),
    .trig_level (trigger_depth),
    .rd_data (fifo_rd),
    .count (fifo_count),
    .words_ready_n (words_ready_n),
    .overrun (buffer_overrun)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [9:0] since_start_q;
  always_ff @(posedge sys_clk)
  begin
    if (rst || (ss_q == SS_IDLE && start_fall))
      since_start_q <= 10'h000;
    else if (ce && since_start_q != 10'h3FF)
      since_start_q <= since_start_q + 10'h001;
  end

  property p_bus_okay;
    @(posedge sys_clk) disable iff (rst) hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not OKAY ready");

  property p_first_word_time;
    @(posedge sys_clk) disable iff (rst)
      ce && single_mode && ss_q == SS_CONV && osc_tick && !chan_q
      && tick_cnt_q == 4'(SS_CONV_TICKS - 1)
      |-> since_start_q == 10'((SS_PIPE_TICKS + SS_CONV_TICKS) * OSC_CYC - 1);
  endproperty
  a_first_word_time: assert property (p_first_word_time) else $error("first word late"); // R6

  property p_hold_on_start;
    @(posedge sys_clk) disable iff (rst)
      ce && single_mode && ss_q == SS_IDLE && start_fall && !fifo_clr_q
      |=> hold0_q == $past(raw_ch0) && hold1_q == $past(raw_ch1) && ss_q == SS_PIPE;
  endproperty
  a_hold_on_start: assert property (p_hold_on_start) else $error("inputs not held"); // R4

  property p_no_write_filling;
    @(posedge sys_clk) disable iff (rst)
      ce && !single_mode && samp_rise && fill_q != CONT_PIPE_EDGES |=> !word_bus.valid;
  endproperty
  a_no_write_filling: assert property (p_no_write_filling) else $error("write in fill"); // R19

  property p_cont_write;
    @(posedge sys_clk) disable iff (rst)
      ce && !single_mode && !fifo_clr_q && samp_rise && fill_q == CONT_PIPE_EDGES
      |=> word_bus.valid;
  endproperty
  a_cont_write: assert property (p_cont_write) else $error("missed conversion write"); // R8

  property p_twos_msb;
    @(posedge sys_clk) disable iff (rst)
      ce && !single_mode && !fifo_clr_q && samp_rise && fill_q == CONT_PIPE_EDGES
      && twos_comp && !two_ch
      |=> word_bus.data == {~$past(raw_ch0[DW-1]), $past(raw_ch0[DW-2:0])};
  endproperty
  a_twos_msb: assert property (p_twos_msb) else $error("bad twos coding"); // R12

  property p_osc_off;
    @(posedge sys_clk) disable iff (rst) !single_mode |-> !osc_tick;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator runs in continuous"); // R7

  c_single_two: cover property (@(posedge sys_clk) disable iff (rst)
    single_mode && two_ch && word_bus.valid && chan_q == 1'b0 && ss_q == SS_IDLE);
  c_cont_ready: cover property (@(posedge sys_clk) disable iff (rst)
    !single_mode && !words_ready_n);
  c_pop: cover property (@(posedge sys_clk) disable iff (rst) pop && fifo_count != '0);
endmodule : dacf_top
`default_nettype wire

// *** rtl/dacf_word_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface dacf_word_if;
  logic valid;
  logic [dacf_pkg::DW-1:0] data;
  modport src (output valid, output data);
  modport snk (input valid, input data);
endinterface : dacf_word_if
`default_nettype wire

// *** test/dacf_front.sv ***
`timescale 1ns/1ns
`default_nettype none
module dacf_front #(
  parameter int HALF = 8,
  parameter int MIN_GAP = 47
) (
  // Clock
  input wire logic sys_clk,
  input wire logic rst,
  // Bench requests
  input wire logic run,
  input wire logic fire,
  // Converter pins
  output logic sample_clock_in,
  output logic start_pulse_n
);
  int unsigned ph_q;
  int unsigned gap_q;
  // Sample clock stands low outside bursts; 16-cycle period stays under 8 MSPS
  always_ff @(posedge sys_clk)
  begin
    if (rst || !run)
    begin
      ph_q <= 0;
      sample_clock_in <= 1'b0;
    end
    else if (ph_q == HALF - 1)
    begin
      ph_q <= 0;
      sample_clock_in <= ~sample_clock_in;
    end
    else
      ph_q <= ph_q + 1;
  end
  // Start pulse, five cycles low; refused again until the gap has run out
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      gap_q <= 0;
      start_pulse_n <= 1'b1;
    end
    else if (fire && gap_q == 0)
    begin
      gap_q <= MIN_GAP;
      start_pulse_n <= 1'b0;
    end
    else
    begin
      if (gap_q != 0)
        gap_q <= gap_q - 1;
      if (gap_q < MIN_GAP - 3)
        start_pulse_n <= 1'b1;
    end
  end
endmodule : dacf_front
`default_nettype wire

// *** test/tb_dacf_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_dacf_top;
  import dacf_pkg::*;
  logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, run, fire;
  logic start_pulse_n, sample_clock_in, words_ready_n, buffer_overrun;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [DW-1:0] raw_ch0, raw_ch1, r0;
  int n_errors = 0;
  int compares = 0;
  int dep[4] = '{1, 4, 8, 14};
  logic [DW-1:0] vals[4] = '{10'h3FF, 10'h200, 10'h000, 10'h155};

  dacf_top dut_u (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .start_pulse_n(start_pulse_n),
    .sample_clock_in(sample_clock_in), .raw_ch0(raw_ch0), .raw_ch1(raw_ch1),
    .words_ready_n(words_ready_n), .buffer_overrun(buffer_overrun));
  dacf_front far_u (.sys_clk(sys_clk), .rst(rst), .run(run), .fire(fire),
    .sample_clock_in(sample_clock_in), .start_pulse_n(start_pulse_n));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [DW-1:0] coded(input logic [DW-1:0] raw, input logic twos);
    return twos ? (raw ^ 10'h200) : raw;
  endfunction : coded

  task automatic conclude;
    $display("counts: %0d compares, %0d mismatches", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic hr_wait;
    int i;
    for (i = 0; i < 20; i++)
    begin
      @(posedge sys_clk);
      if (hreadyout === 1'b1)
        return;
    end
    n_errors++;
    conclude();
  endtask : hr_wait

  // Single transfer: address phase held until hready, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hr_wait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    hr_wait();
    rd = hrdata;
    chk(hresp, 1'b0, "bus response");
  endtask : ahb

  // Count sample-clock rises and cycles until the ready pulse shows
  task automatic wait_ready(output int rises, output int cyc);
    logic prev;
    prev = sample_clock_in;
    rises = 0;
    for (cyc = 1; cyc < 2000; cyc++)
    begin
      @(posedge sys_clk);
      #1;
      if (sample_clock_in && !prev)
        rises++;
      prev = sample_clock_in;
      if (words_ready_n === 1'b0)
        return;
    end
    n_errors++;
    conclude();
  endtask : wait_ready

  task automatic shot(input int nch);
    int rs, cyc;
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    wait_ready(rs, cyc);
    chk(cyc, (SS_PIPE_TICKS + SS_CONV_TICKS * nch) * OSC_CYC + 2, "ready delay");
    chk(rs, 0, "no sample clock in single mode");
    @(posedge sys_clk);
    #1;
    chk(words_ready_n, 1'b1, "pulse width");
    @(posedge sys_clk);
  endtask : shot

  initial
  begin
    int rs, cyc;
    logic prev_clk;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    run = 1'b0;
    fire = 1'b0;
    raw_ch0 = 10'h000;
    raw_ch1 = 10'h000;
    void'($urandom(27));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    ahb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0, "status after reset");
    chk(buffer_overrun, 1'b0, "overrun after reset");
    // Output coding, single channel, single-shot
    for (int i = 0; i < 8; i++)
    begin
      r0 = (i % 4 == 3) ? DW'($urandom) : vals[i % 4];
      raw_ch0 <= r0;
      ahb(1'b1, ADDR_CTRL_B, {24'h0, i[0], 7'h0});
      ahb(1'b1, ADDR_CTRL_A, {26'h0, i[2], 5'h0A});
      shot(1);
      ahb(1'b0, ADDR_DATA, 32'h0);
      chk(rd, {22'h0, coded(r0, i[0])}, "coded word");
    end
    $display("test coding done");
    // Two channels together, channel 0 first
    r0 = DW'($urandom);
    raw_ch0 <= r0;
    raw_ch1 <= ~r0;
    ahb(1'b1, ADDR_CTRL_B, 32'h0);
    ahb(1'b1, ADDR_CTRL_A, 32'h1A);
    shot(2);
    ahb(1'b0, ADDR_DATA, 32'h0);
    chk(rd, {22'h0, r0}, "first word ch0");
    ahb(1'b0, ADDR_DATA, 32'h0);
    chk(rd, {22'h0, ~r0}, "second word ch1");
    $display("test two channel done");
    // Continuous: first event at 7 plus depth rises for every depth code
    ahb(1'b1, ADDR_CTRL_A, 32'h08);
    for (int c = 0; c < 4; c++)
    begin
      ahb(1'b1, ADDR_CTRL_B, {24'h0, c[0], 3'h0, c[1:0], 2'b10});
      run <= 1'b1;
      wait_ready(rs, cyc);
      chk(rs, 7 + dep[c], "first event rises");
      // Back on the edge so the next bus call starts right after it
      @(posedge sys_clk);
      if (c < 3)
        run <= 1'b0;
    end
    $display("test continuous done");
    // Keep writing with no reads until the ring overflows
    prev_clk = sample_clock_in;
    for (cyc = 0; cyc < 2000 && buffer_overrun !== 1'b1; cyc++)
    begin
      @(posedge sys_clk);
      #1;
      if (sample_clock_in && !prev_clk)
        rs++;
      prev_clk = sample_clock_in;
    end
    if (buffer_overrun !== 1'b1)
    begin
      n_errors++;
      conclude();
    end
    @(posedge sys_clk);
    run <= 1'b0;
    chk(rs, 7 + FIFO_DEPTH + 1, "overflow on 17th write");
    ahb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[8:0], 9'h101, "full and overrun");
    ahb(1'b0, ADDR_DATA, 32'h0);
    chk(rd, {22'h0, coded(raw_ch0, 1'b1)}, "popped word");
    ahb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[8:4], 5'h0F, "count after pop");
    chk(buffer_overrun, 1'b1, "overrun sticky");
    ahb(1'b1, ADDR_CTRL_B, 32'h2);
    // Buffer reset strobe acts one edge after the write lands
    @(posedge sys_clk);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0, "cleared by buffer reset");
    ahb(1'b0, ADDR_DATA, 32'h0);
    chk(rd, 32'h0, "empty read");
    chk(buffer_overrun, 1'b0, "overrun pin low");
    $display("test overflow done");
    conclude();
  end
endmodule : tb_dacf_top
`default_nettype wire
